// [hw/alu_timing_cfg.svh]
/*
 Constants for the arithmetic and logic group decoder: opcode nibbles,
 instruction lengths, cycle counts and reset values.
 Assumes inclusion by bare name before any module that uses them.
*/
`ifndef ALU_TIMING_CFG_SVH
`define ALU_TIMING_CFG_SVH

`define HI_ADD          4'h2
`define HI_ADD_CARRY    4'h3
`define HI_OR           4'h4
`define HI_AND          4'h5
`define HI_XOR          4'h6
`define HI_SUB_BORROW   4'h9

`define LO_DIR_ACC      4'h2
`define LO_DIR_IMM      4'h3
`define LO_IMM          4'h4
`define LO_DIR          4'h5
`define LO_IND_HI       3'h3

`define LEN_NONE        2'h0
`define LEN_ONE         2'h1
`define LEN_TWO         2'h2
`define LEN_THREE       2'h3

`define CYC_ONE         2'h1
`define CYC_TWO         2'h2
`define CYC_THREE       2'h3

`define RESET_BYTE      8'h00
`define RESET_SEL       3'h0

`endif

// [hw/alu_timing_pkg.sv]
/*
 Types shared by the arithmetic and logic group decoder modules.
 Assumes nothing of its surroundings.
*/
package alu_timing_pkg;

    typedef enum logic [2:0] {
        op_none            = 3'h0,
        op_add             = 3'h1,
        add_with_carry_op  = 3'h2,
        subtract_borrow_op = 3'h3,
        bitwise_and_op     = 3'h4,
        bitwise_or_op      = 3'h5,
        bitwise_xor_op     = 3'h6
    } alu_op_t;

    typedef enum logic [2:0] {
        no_mode                   = 3'h0,
        bank_register             = 3'h1,
        indirect_pointer_register = 3'h2,
        direct_byte_mode          = 3'h3,
        immediate_mode            = 3'h4,
        direct_from_acc_mode      = 3'h5,
        direct_immediate_mode     = 3'h6
    } addr_mode_t;

    typedef enum logic [0:0] {
        st_idle = 1'b0,
        st_exec = 1'b1
    } seq_state_t;

endpackage : alu_timing_pkg

// [hw/alu_op_classify.sv]
/*
 Combinational classifier: turns an opcode byte into operation,
 addressing form, length in bytes and execution time in core cycles.
 Assumes the opcode is stable while it is looked at.
*/
`timescale 1ns/1ps
`include "alu_timing_cfg.svh"

module alu_op_classify
    import alu_timing_pkg::*;
(
    input  wire logic [7:0] opcode_i,   // Opcode byte
    output alu_op_t         op_o,       // Operation
    output addr_mode_t      mode_o,     // Addressing form
    output logic      [1:0] len_o,      // Length in bytes
    output logic      [1:0] cyc_o,      // Core cycles
    output logic            ok_o        // Opcode belongs to the group
);

    function automatic alu_op_t op_of(input logic [3:0] hi);
        case (hi)
            `HI_ADD:  op_of = op_add;
            `HI_ADD_CARRY:  op_of = add_with_carry_op;
            `HI_SUB_BORROW: op_of = subtract_borrow_op;
            `HI_AND:        op_of = bitwise_and_op;
            `HI_OR:         op_of = bitwise_or_op;
            `HI_XOR:        op_of = bitwise_xor_op;
            default:  op_of = op_none;
        endcase
    endfunction : op_of

    function automatic logic is_logic(input alu_op_t op);
        is_logic = (op == bitwise_and_op) || (op == bitwise_or_op) || (op == bitwise_xor_op);
    endfunction : is_logic

    always_comb
    begin
        op_o   = op_of(opcode_i[7:4]);
        mode_o = no_mode;
        len_o  = `LEN_NONE;
        cyc_o  = `CYC_ONE;
        if (opcode_i[3])
        begin
            mode_o = bank_register;
            len_o  = `LEN_ONE;
            cyc_o  = `CYC_ONE;
        end
        else if (opcode_i[3:1] == `LO_IND_HI)
        begin
            mode_o = indirect_pointer_register;
            len_o  = `LEN_ONE;
            cyc_o  = `CYC_TWO;
        end
        else if (opcode_i[3:0] == `LO_DIR)
        begin
            mode_o = direct_byte_mode;
            len_o  = `LEN_TWO;
            cyc_o  = `CYC_TWO;
        end
        else if (opcode_i[3:0] == `LO_IMM)
        begin
            mode_o = immediate_mode;
            len_o  = `LEN_TWO;
            cyc_o  = `CYC_TWO;
        end
        else if (opcode_i[3:0] == `LO_DIR_ACC && is_logic(op_o))
        begin
            mode_o = direct_from_acc_mode;
            len_o  = `LEN_TWO;
            cyc_o  = `CYC_TWO;
        end
        else if (opcode_i[3:0] == `LO_DIR_IMM && is_logic(op_o))
        begin
            mode_o = direct_immediate_mode;
            len_o  = `LEN_THREE;
            cyc_o  = `CYC_THREE;
        end
        ok_o = (op_o != op_none) && (mode_o != no_mode);
    end

endmodule : alu_op_classify

// [hw/cycle_count.sv]
/*
 Counter of elapsed core cycles of the instruction in flight.
 Assumes load and step are never raised together.
*/
`timescale 1ns/1ps

module cycle_count #(
    parameter int W = 2
) (
    input  wire logic         clk_i,       // Core clock
    input  wire logic         reset_n_i,   // Asynchronous reset, active low
    input  wire logic         clk_en_i,    // Clock enable
    input  wire logic         load_i,      // Start at the first cycle
    input  wire logic         step_i,      // One more cycle elapsed
    input  wire logic [W-1:0] target_i,    // Total cycles
    output logic      [W-1:0] count_o,     // Cycles elapsed
    output logic              next_last_o  // Next step ends the instruction
);

    typedef struct packed {
        logic [W-1:0] count;
    } cnt_state_t;

    cnt_state_t cur;
    cnt_state_t next_cur;

    always_comb
    begin
        next_cur = cur;
        if (load_i)
            next_cur.count = W'(1);
        else if (step_i)
            next_cur.count = W'(cur.count + W'(1));
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cur <= '0;
        else if (clk_en_i)
            cur <= next_cur;
    end

    assign count_o     = cur.count;
    assign next_last_o = (W'(cur.count + W'(1)) == target_i);

endmodule : cycle_count

// [hw/single_cycle_alu_op_timing.sv]
/*
 Decode and timing sequencer for the arithmetic and logic instruction
 group of a single-cycle accumulator core. Takes opcode and operand bytes
 from fetch, reports length, collects operands and paces execution.
 Assumes fetch offers one byte per cycle on the core clock and holds a
 byte until it is taken.
*/
`timescale 1ns/1ps
`include "alu_timing_cfg.svh"

// Overview of operation
// - Add register, with carry: one byte, one cycle.
// - Subtract register with borrow: one byte, one cycle.
// - Add indirect memory: one byte, two cycles.
// - Add direct with carry: two bytes, two cycles.
// - Add immediate with carry: two bytes, two cycles.
// - Subtract direct with borrow: two bytes, two cycles.
// - Subtract immediate with borrow: two bytes, two cycles.
// - AND indirect memory: one byte, two cycles.
// - AND direct to accumulator: two bytes, two cycles.
// - AND accumulator into direct: two bytes, two cycles.
// - AND immediate into direct: three bytes, three cycles.
// - OR indirect memory: one byte, two cycles.
// - OR immediate into direct: three bytes, three cycles.
// - XOR register: one byte, one cycle.
// - XOR immediate: two bytes, two cycles.
// - XOR accumulator into direct: two bytes, two cycles.
// - XOR immediate into direct: three bytes, three cycles.
module single_cycle_alu_op_timing
    import alu_timing_pkg::*;
(
    input  wire logic       clk_i,         // Core clock, 10 MHz
    input  wire logic       reset_n_i,     // Asynchronous reset, active low
    input  wire logic       clk_en_i,      // Clock enable, freezes state when low
    input  wire logic       byte_valid_i,  // Fetch offers a code byte
    input  wire logic [7:0] byte_i,        // Code byte from fetch
    output logic            byte_ready_o,  // Decoder takes the offered byte
    output logic            len_valid_o,   // Pulse: new opcode decoded
    output logic      [1:0] insn_len_o,    // Length in bytes of last opcode
    output logic      [1:0] insn_cycles_o, // Core cycles of last opcode
    output alu_op_t         op_o,          // Operation for the datapath
    output addr_mode_t      mode_o,        // Addressing form
    output logic      [2:0] reg_sel_o,     // Bank register or pointer select
    output logic      [7:0] operand_a_o,   // First operand byte
    output logic      [7:0] operand_b_o,   // Second operand byte
    output logic            mem_read_o,    // Operand comes from memory
    output logic            wb_direct_o,   // Result goes to the direct byte
    output logic            exec_start_o,  // Pulse: all operand bytes present
    output logic            retire_o,      // Pulse: instruction completed
    output logic            busy_o,        // Multi-cycle instruction in flight
    output logic            unsupported_o, // Pulse: opcode outside this group
    output logic      [1:0] cycle_o        // Cycles elapsed in instruction
);

    typedef struct packed {
        seq_state_t st;
        alu_op_t    op;
        addr_mode_t mode;
        logic [1:0] len;
        logic [1:0] total;
        logic [1:0] got;
        logic [2:0] reg_sel;
        logic [7:0] operand_a;
        logic [7:0] operand_b;
        logic       len_valid;
        logic       exec_start;
        logic       retire;
        logic       unsupported;
    } seq_t;

    localparam seq_t SEQ_RESET = '{
        st:          st_idle,
        op:          op_none,
        mode:        no_mode,
        len:         `LEN_NONE,
        total:       `CYC_ONE,
        got:         `LEN_NONE,
        reg_sel:     `RESET_SEL,
        operand_a:   `RESET_BYTE,
        operand_b:   `RESET_BYTE,
        len_valid:   1'b0,
        exec_start:  1'b0,
        retire:      1'b0,
        unsupported: 1'b0
    };

    seq_t       cur;
    seq_t       next_cur;

    alu_op_t    dec_op;
    addr_mode_t dec_mode;
    logic [1:0] dec_len;
    logic [1:0] dec_cyc;
    logic       dec_ok;

    logic       cnt_load;
    logic       cnt_step;
    logic [1:0] cnt_count;
    logic       cnt_next_last;
    logic       need_byte;
    logic [1:0] got_plus;

    alu_op_classify i_alu_op_classify (
        .opcode_i (byte_i),
        .op_o     (dec_op),
        .mode_o   (dec_mode),
        .len_o    (dec_len),
        .cyc_o    (dec_cyc),
        .ok_o     (dec_ok)
    );

    cycle_count #(
        .W (2)
    ) i_cycle_count (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .clk_en_i    (clk_en_i),
        .load_i      (cnt_load),
        .step_i      (cnt_step),
        .target_i    (cur.total),
        .count_o     (cnt_count),
        .next_last_o (cnt_next_last)
    );

    // Operand bytes are still owed while fewer than the length were taken.
    assign need_byte = (cur.got < cur.len);
    assign got_plus  = 2'(cur.got + 2'h1);

    // An internal cycle, such as the memory read of an indirect operand,
    // takes no code byte, so fetch is held off then.
    always_comb
    begin
        case (cur.st)
            st_idle:
                byte_ready_o = 1'b1;
            st_exec:
                byte_ready_o = need_byte;
            default:
                byte_ready_o = 1'b0;
        endcase
    end

    always_comb
    begin
        next_cur             = cur;
        next_cur.len_valid   = 1'b0;
        next_cur.exec_start  = 1'b0;
        next_cur.retire      = 1'b0;
        next_cur.unsupported = 1'b0;
        cnt_load             = 1'b0;
        cnt_step             = 1'b0;
        case (cur.st)
            st_idle:
            begin
                if (byte_valid_i)
                begin
                    if (dec_ok)
                    begin
                        next_cur.op        = dec_op;
                        next_cur.mode      = dec_mode;
                        next_cur.len       = dec_len;
                        next_cur.total     = dec_cyc;
                        next_cur.got       = `LEN_ONE;
                        next_cur.reg_sel   = byte_i[2:0];
                        next_cur.len_valid = 1'b1;
                        cnt_load           = 1'b1;
                        if (dec_len == `LEN_ONE)
                            next_cur.exec_start = 1'b1;
                        if (dec_cyc == `CYC_ONE)
                        begin
                            // Register forms finish in the cycle they are taken.
                            next_cur.retire = 1'b1;
                        end
                        else
                        begin
                            next_cur.st = st_exec;
                        end
                    end
                    else
                    begin
                        next_cur.op          = op_none;
                        next_cur.mode        = no_mode;
                        next_cur.len         = `LEN_NONE;
                        next_cur.total       = `CYC_ONE;
                        next_cur.unsupported = 1'b1;
                    end
                end
            end
            st_exec:
            begin
                if (need_byte)
                begin
                    // A stalled fetch stretches the instruction, not the count.
                    if (byte_valid_i)
                    begin
                        if (cur.got == `LEN_ONE)
                            next_cur.operand_a = byte_i;
                        else
                            next_cur.operand_b = byte_i;
                        next_cur.got = got_plus;
                        cnt_step     = 1'b1;
                        if (got_plus == cur.len)
                            next_cur.exec_start = 1'b1;
                    end
                end
                else
                begin
                    cnt_step = 1'b1;
                end
                if (cnt_step && cnt_next_last)
                begin
                    next_cur.st     = st_idle;
                    next_cur.retire = 1'b1;
                end
            end
            default:
            begin
                next_cur = SEQ_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cur <= SEQ_RESET;
        else if (clk_en_i)
            cur <= next_cur;
    end

    // Three-byte forms write back to the direct byte; so do the
    // accumulator-into-direct forms.
    always_comb
    begin
        case (cur.mode)
            direct_from_acc_mode:
            begin
                mem_read_o  = 1'b1;
                wb_direct_o = 1'b1;
            end
            direct_immediate_mode:
            begin
                mem_read_o  = 1'b1;
                wb_direct_o = 1'b1;
            end
            indirect_pointer_register:
            begin
                mem_read_o  = 1'b1;
                wb_direct_o = 1'b0;
            end
            direct_byte_mode:
            begin
                mem_read_o  = 1'b1;
                wb_direct_o = 1'b0;
            end
            default:
            begin
                mem_read_o  = 1'b0;
                wb_direct_o = 1'b0;
            end
        endcase
    end

    assign len_valid_o   = cur.len_valid;
    assign insn_len_o    = cur.len;
    assign insn_cycles_o = cur.total;
    assign op_o          = cur.op;
    assign mode_o        = cur.mode;
    assign reg_sel_o     = cur.reg_sel;
    assign operand_a_o   = cur.operand_a;
    assign operand_b_o   = cur.operand_b;
    assign exec_start_o  = cur.exec_start;
    assign retire_o      = cur.retire;
    assign busy_o        = (cur.st == st_exec);
    assign unsupported_o = cur.unsupported;
    assign cycle_o       = cnt_count;

endmodule : single_cycle_alu_op_timing

// [sim/single_cycle_alu_op_timing_sva.sv]
/*
 Concurrent checks for the arithmetic and logic group decoder.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps

module single_cycle_alu_op_timing_sva
    import alu_timing_pkg::*;
(
    input wire logic       clk_i,         // Core clock
    input wire logic       reset_n_i,     // Asynchronous reset, active low
    input wire logic       clk_en_i,      // Clock enable
    input wire logic       byte_valid_i,  // Fetch offers a byte
    input wire logic [7:0] byte_i,        // Code byte
    input wire logic       byte_ready_o,  // Byte taken
    input wire logic       len_valid_o,   // Opcode decoded
    input wire logic [1:0] insn_len_o,    // Length in bytes
    input wire logic [1:0] insn_cycles_o, // Core cycles
    input addr_mode_t      mode_o,        // Addressing form
    input wire logic [7:0] operand_a_o,   // Second code byte
    input wire logic [7:0] operand_b_o,   // Third code byte
    input wire logic       mem_read_o,    // Memory operand
    input wire logic       wb_direct_o,   // Direct write back
    input wire logic       exec_start_o,  // Operands complete
    input wire logic       retire_o,      // Instruction done
    input wire logic       busy_o,        // Multi-cycle in flight
    input wire logic       unsupported_o, // Foreign opcode
    input wire logic [1:0] cycle_o        // Cycles elapsed
);
    logic [1:0] len_w;
    logic [1:0] cyc_w;
    logic       take;
    logic       opc_take;

    // Length and cycle count of an opcode byte; zero length outside the group.
    function automatic logic [3:0] classify(input logic [7:0] b);
        logic grp;
        logic lgc;
        grp = b[7:4] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};
        lgc = b[7:4] inside {4'h4, 4'h5, 4'h6};
        classify = 4'h0;
        if (grp && b[3])
            classify = 4'h5;
        else if (grp && b[3:1] == 3'h3)
            classify = 4'h6;
        else if (grp && b[3:1] == 3'h2)
            classify = 4'ha;
        else if (lgc && b[3:0] == 4'h2)
            classify = 4'ha;
        else if (lgc && b[3:0] == 4'h3)
            classify = 4'hf;
    endfunction : classify

    assign len_w    = 2'(classify(byte_i) >> 2);
    assign cyc_w    = 2'(classify(byte_i) & 4'h3);
    assign take     = clk_en_i && byte_valid_i && byte_ready_o;
    assign opc_take = take && !busy_o;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_ind_take;
        opc_take && len_w == 2'h1 && cyc_w == 2'h2;
    endsequence
    sequence s_ind_wait;
        busy_o && !byte_ready_o && cycle_o == 2'h1;
    endsequence
    sequence s_two_take;
        opc_take && len_w == 2'h2;
    endsequence
    sequence s_three_take;
        opc_take && len_w == 2'h3;
    endsequence

    chk_len_report: assert property (opc_take && len_w != 2'h0 |=>
        len_valid_o && insn_len_o == $past(len_w)) else $error("length report wrong");
    chk_cyc_report: assert property (opc_take && len_w != 2'h0 |=>
        insn_cycles_o == $past(cyc_w) && cycle_o == 2'h1) else $error("cycle report wrong");
    chk_unsup_flag: assert property (opc_take && len_w == 2'h0 |=>
        unsupported_o && !len_valid_o && insn_len_o == 2'h0) else $error("foreign opcode wrong");
    chk_single_retire: assert property (opc_take && cyc_w == 2'h1 |=>
        retire_o && exec_start_o && !busy_o) else $error("one-cycle op not retired");
    chk_ind_hold: assert property (s_ind_take |=> s_ind_wait)
        else $error("indirect op not held");
    chk_ind_retire: assert property (s_ind_take ##1 (busy_o && clk_en_i) |=>
        retire_o && !busy_o && cycle_o == 2'h2) else $error("indirect op late");
    chk_two_byte: assert property (s_two_take ##1 take |=>
        retire_o && exec_start_o && operand_a_o == $past(byte_i)) else $error("two-byte op");
    chk_three_byte: assert property (s_three_take ##1 take [*2] |=>
        retire_o && operand_b_o == $past(byte_i)) else $error("three-byte op");
    chk_busy_refuse: assert property (busy_o && !byte_ready_o && clk_en_i |=>
        !len_valid_o && !unsupported_o) else $error("byte taken while refused");
    chk_freeze_hold: assert property (!clk_en_i |=> $stable(retire_o) &&
        $stable(busy_o) && $stable(cycle_o) && $stable(insn_len_o)) else $error("state moved");
    chk_mode_flags: assert property (wb_direct_o == (mode_o inside
        {direct_from_acc_mode, direct_immediate_mode}) && mem_read_o == (mode_o inside
        {indirect_pointer_register, direct_byte_mode, direct_from_acc_mode,
        direct_immediate_mode})) else $error("mode flags wrong");

    cov_three_byte: cover property (s_three_take);
endmodule : single_cycle_alu_op_timing_sva

bind single_cycle_alu_op_timing single_cycle_alu_op_timing_sva i_single_cycle_alu_op_timing_sva (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .byte_valid_i(byte_valid_i),
    .byte_i(byte_i), .byte_ready_o(byte_ready_o), .len_valid_o(len_valid_o),
    .insn_len_o(insn_len_o), .insn_cycles_o(insn_cycles_o), .mode_o(mode_o),
    .operand_a_o(operand_a_o), .operand_b_o(operand_b_o), .mem_read_o(mem_read_o),
    .wb_direct_o(wb_direct_o), .exec_start_o(exec_start_o), .retire_o(retire_o),
    .busy_o(busy_o), .unsupported_o(unsupported_o), .cycle_o(cycle_o));

// [sim/single_cycle_alu_op_timing_tb.sv]
/*
 Self-checking testbench for the arithmetic and logic group decoder.
 Assumes the checker is bound separately and fetch is played by the bench.
*/
`timescale 1ns/1ps

`define CHECK_EQ(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module single_cycle_alu_op_timing_tb
    import alu_timing_pkg::*;
;

    logic       clk_i;
    logic       reset_n_i;
    logic       clk_en_i;
    logic       byte_valid_i;
    logic [7:0] byte_i;
    logic       byte_ready_o;
    logic       len_valid_o;
    logic [1:0] insn_len_o;
    logic [1:0] insn_cycles_o;
    alu_op_t    op_o;
    addr_mode_t mode_o;
    logic [2:0] reg_sel_o;
    logic [7:0] operand_a_o;
    logic [7:0] operand_b_o;
    logic       mem_read_o;
    logic       wb_direct_o;
    logic       exec_start_o;
    logic       retire_o;
    logic       busy_o;
    logic       unsupported_o;
    logic [1:0] cycle_o;
    int         n_mismatch;
    int         total_checks;

    single_cycle_alu_op_timing i_single_cycle_alu_op_timing (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
        .byte_valid_i(byte_valid_i), .byte_i(byte_i), .byte_ready_o(byte_ready_o),
        .len_valid_o(len_valid_o), .insn_len_o(insn_len_o), .insn_cycles_o(insn_cycles_o),
        .op_o(op_o), .mode_o(mode_o), .reg_sel_o(reg_sel_o), .operand_a_o(operand_a_o),
        .operand_b_o(operand_b_o), .mem_read_o(mem_read_o), .wb_direct_o(wb_direct_o),
        .exec_start_o(exec_start_o), .retire_o(retire_o), .busy_o(busy_o),
        .unsupported_o(unsupported_o), .cycle_o(cycle_o));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop

    // Offers one instruction byte by byte, optionally withholding the operands for gap cycles.
    task automatic run_op(input logic [7:0] opc, input logic [7:0] a, input logic [7:0] b,
                          input logic [1:0] len, input logic [1:0] cyc, input alu_op_t eop,
                          input addr_mode_t emode, input int gap);
        int   edges;
        int   taken;
        int   g;
        logic tk;
        g            = gap;
        byte_i       = opc;
        byte_valid_i = 1'b1;
        @(posedge clk_i);
        #5;
        `CHECK_EQ(len_valid_o, 1'b1)
        `CHECK_EQ(insn_len_o, len)
        `CHECK_EQ(insn_cycles_o, cyc)
        `CHECK_EQ(op_o, eop)
        `CHECK_EQ(mode_o, emode)
        `CHECK_EQ(reg_sel_o, opc[2:0])
        edges = 1;
        taken = 1;
        while (retire_o !== 1'b1 && edges < 12)
        begin
            if (taken < len && g > 0)
            begin
                byte_valid_i = 1'b0;
                g--;
            end
            else if (taken < len)
            begin
                byte_i       = (taken == 1) ? a : b;
                byte_valid_i = 1'b1;
            end
            else
                byte_valid_i = 1'b0;
            tk = byte_valid_i & byte_ready_o;
            @(posedge clk_i);
            #5;
            edges++;
            if (tk === 1'b1)
                taken++;
        end
        `CHECK_EQ(retire_o, 1'b1)
        `CHECK_EQ(edges, int'(cyc) + gap)
        `CHECK_EQ(cycle_o, cyc)
        `CHECK_EQ(taken, int'(len))
        if (len > 2'h1)
            `CHECK_EQ(operand_a_o, a)
        if (len == 2'h3)
            `CHECK_EQ(operand_b_o, b)
        `CHECK_EQ(wb_direct_o, emode inside {direct_from_acc_mode, direct_immediate_mode})
        `CHECK_EQ(mem_read_o, emode inside {indirect_pointer_register, direct_byte_mode,
                  direct_from_acc_mode, direct_immediate_mode})
    endtask : run_op

    task automatic t_reset_vals();
        `CHECK_EQ(byte_ready_o, 1'b1)
        `CHECK_EQ(insn_len_o, 2'h0)
        `CHECK_EQ(insn_cycles_o, 2'h1)
        `CHECK_EQ(busy_o, 1'b0)
        `CHECK_EQ(retire_o, 1'b0)
    endtask : t_reset_vals

    // Arithmetic forms issued back to back.
    task automatic t_arith();
        run_op(8'h3a, 8'h00, 8'h00, 2'h1, 2'h1, add_with_carry_op, bank_register, 0);
        run_op(8'h9b, 8'h00, 8'h00, 2'h1, 2'h1, subtract_borrow_op, bank_register, 0);
        run_op(8'h26, 8'h00, 8'h00, 2'h1, 2'h2, op_add, indirect_pointer_register, 0);
        run_op(8'h35, 8'h7e, 8'h00, 2'h2, 2'h2, add_with_carry_op, direct_byte_mode, 0);
        run_op(8'h34, 8'hff, 8'h00, 2'h2, 2'h2, add_with_carry_op, immediate_mode, 0);
        run_op(8'h95, 8'h81, 8'h00, 2'h2, 2'h2, subtract_borrow_op, direct_byte_mode, 0);
        run_op(8'h94, 8'h01, 8'h00, 2'h2, 2'h2, subtract_borrow_op, immediate_mode, 0);
    endtask : t_arith

    // Logic forms issued back to back, including the three-byte ones.
    task automatic t_logic();
        run_op(8'h56, 8'h00, 8'h00, 2'h1, 2'h2, bitwise_and_op, indirect_pointer_register, 0);
        run_op(8'h55, 8'h5a, 8'h00, 2'h2, 2'h2, bitwise_and_op, direct_byte_mode, 0);
        run_op(8'h52, 8'ha5, 8'h00, 2'h2, 2'h2, bitwise_and_op, direct_from_acc_mode, 0);
        run_op(8'h53, 8'h3c, 8'hc3, 2'h3, 2'h3, bitwise_and_op, direct_immediate_mode, 0);
        run_op(8'h47, 8'h00, 8'h00, 2'h1, 2'h2, bitwise_or_op, indirect_pointer_register, 0);
        run_op(8'h43, 8'h0f, 8'hf0, 2'h3, 2'h3, bitwise_or_op, direct_immediate_mode, 0);
        run_op(8'h6f, 8'h00, 8'h00, 2'h1, 2'h1, bitwise_xor_op, bank_register, 0);
        run_op(8'h64, 8'h96, 8'h00, 2'h2, 2'h2, bitwise_xor_op, immediate_mode, 0);
        run_op(8'h62, 8'h69, 8'h00, 2'h2, 2'h2, bitwise_xor_op, direct_from_acc_mode, 0);
        run_op(8'h63, 8'h12, 8'hed, 2'h3, 2'h3, bitwise_xor_op, direct_immediate_mode, 0);
    endtask : t_logic

    // Fetch withholds operand bytes; every byte must still be collected.
    task automatic t_stall();
        run_op(8'h53, 8'h44, 8'hbb, 2'h3, 2'h3, bitwise_and_op, direct_immediate_mode, 2);
        run_op(8'h95, 8'h66, 8'h00, 2'h2, 2'h2, subtract_borrow_op, direct_byte_mode, 1);
    endtask : t_stall

    task automatic t_unsup();
        byte_i       = 8'h00;
        byte_valid_i = 1'b1;
        @(posedge clk_i);
        #5;
        `CHECK_EQ(unsupported_o, 1'b1)
        `CHECK_EQ(len_valid_o, 1'b0)
        byte_i = 8'h22;
        @(posedge clk_i);
        #5;
        `CHECK_EQ(unsupported_o, 1'b1)
        `CHECK_EQ(insn_len_o, 2'h0)
        run_op(8'h3b, 8'h00, 8'h00, 2'h1, 2'h1, add_with_carry_op, bank_register, 0);
    endtask : t_unsup

    // With the clock enable low nothing is taken and pulses hold.
    task automatic t_clk_en();
        clk_en_i     = 1'b0;
        byte_i       = 8'h98;
        byte_valid_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #5;
        `CHECK_EQ(op_o, add_with_carry_op)
        `CHECK_EQ(reg_sel_o, 3'h3)
        clk_en_i = 1'b1;
        @(posedge clk_i);
        #5;
        `CHECK_EQ(retire_o, 1'b1)
        `CHECK_EQ(op_o, subtract_borrow_op)
        clk_en_i = 1'b0;
        @(posedge clk_i);
        #5;
        `CHECK_EQ(retire_o, 1'b1)
        `CHECK_EQ(len_valid_o, 1'b1)
        clk_en_i     = 1'b1;
        byte_valid_i = 1'b0;
        @(posedge clk_i);
        #5;
        `CHECK_EQ(retire_o, 1'b0)
    endtask : t_clk_en

    initial
    begin
        n_mismatch   = 0;
        total_checks = 0;
        reset_n_i    = 1'b0;
        clk_en_i     = 1'b1;
        byte_valid_i = 1'b0;
        byte_i       = 8'h00;
        repeat (5) @(posedge clk_i);
        #5;
        t_reset_vals();
        reset_n_i = 1'b1;
        @(posedge clk_i);
        #5;
        t_arith();
        t_logic();
        t_stall();
        t_unsup();
        t_clk_en();
        report_and_stop();
    end

    initial
    begin
        #(100 * 2000);
        n_mismatch++;
        report_and_stop();
    end
endmodule : single_cycle_alu_op_timing_tb
